// [vpi_irq_enable.sv]
// Video port interrupt enable register and request combiner
`timescale 1ns/100ps
`include "video_irq_source_enable_cfg.svh"
module vpi_irq_enable (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Register port
    input  wire vpi_pkg::vpi_addr_t reg_addr,
    input  wire vpi_pkg::vpi_word_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // Pending flags from the status register outside
    input  wire vpi_pkg::vpi_word_t pend_flags,
    // Interrupt request to the processor
    output logic                    video_irq
);
    import vpi_pkg::*;

    // ----------------------------------------------------------------
    // Enable register
    // ----------------------------------------------------------------
    vpi_word_t src_en_q;
    vpi_word_t src_en_d;
    vpi_word_t rdata_q;
    vpi_word_t rdata_d;
    logic      irq_q;
    logic      irq_d;
    logic      irq_raw;

    // Reserved positions are masked on write so they can never hold a one
    always_comb begin
        src_en_d = src_en_q;
        if (reg_wr && reg_addr == `VPI_IDX_SRC_EN) begin
            src_en_d = reg_wdata & `VPI_EN_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Pending flags read back at their own index; unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `VPI_IDX_SRC_EN: rdata_d = src_en_q & `VPI_EN_MASK;
                `VPI_IDX_PEND:   rdata_d = pend_flags & `VPI_SRC_MASK;
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Request combiner
    // ----------------------------------------------------------------
    // Registered so the output comes from a flop; costs one cycle of latency
    vpi_irq_combine u_combine (
        .pend    (pend_flags),
        .enable  (src_en_q),
        .irq_raw (irq_raw)
    );

    always_comb begin
        irq_d = irq_raw;
    end

    // ----------------------------------------------------------------
    // Per-source lanes
    // ----------------------------------------------------------------
    // One lane per bit; reserved lanes and the gate lane are tied low so a
    // stray pending bit there can never leak into a group or the request
    wire vpi_word_t lane_pass;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_lane
            if (((`VPI_SRC_MASK >> gi) & 32'h0000_0001) != 32'h0000_0000) begin : g_src
                assign lane_pass[gi] = pend_flags[gi] & src_en_q[gi];
            end else begin : g_tie
                assign lane_pass[gi] = 1'b0;
            end
        end
    endgenerate

    // Group view of the lanes, for the checks only; it does not feed the request
    logic grp_cha;
    logic grp_chb;
    logic grp_disp;
    logic grp_misc;

    always_comb begin
        grp_cha  = |lane_pass[`VPI_BIT_CHA_LONG:`VPI_BIT_CHA_OVR];
        grp_chb  = |lane_pass[`VPI_BIT_CHB_LONG:`VPI_BIT_CHB_OVR];
        grp_disp = |lane_pass[`VPI_BIT_DISP_UNACK:`VPI_BIT_DISP_UNDR];
        grp_misc = lane_pass[`VPI_BIT_GPIO] | lane_pass[`VPI_BIT_TICK]
                   | lane_pass[`VPI_BIT_SYSTIME];
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_en_q <= `VPI_EN_RESET;
            rdata_q  <= 32'h0000_0000;
            irq_q    <= 1'b0;
        end else begin
            src_en_q <= src_en_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign video_irq = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_en_write;
        reg_wr && reg_addr == `VPI_IDX_SRC_EN;
    endsequence

    a_write_updates: assert property (@(posedge clk) disable iff (!rst_n)
        s_en_write |=> src_en_q == ($past(reg_wdata) & `VPI_EN_MASK))
        else $error("enable register did not take written value");

    a_hold_value: assert property (@(posedge clk) disable iff (!rst_n)
        !(reg_wr && reg_addr == `VPI_IDX_SRC_EN) |=> $stable(src_en_q))
        else $error("enable register changed without a write");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (src_en_q & ~`VPI_EN_MASK) == 32'h0000_0000)
        else $error("reserved enable bit set");

    a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        !src_en_q[`VPI_BIT_GATE] |=> !video_irq)
        else $error("interrupt raised with global gate off");

    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> video_irq == ($past(src_en_q[`VPI_BIT_GATE])
            & (|($past(pend_flags) & $past(src_en_q) & `VPI_SRC_MASK))))
        else $error("interrupt request mismatch");

    a_chb_long: assert property (@(posedge clk) disable iff (!rst_n)
        (src_en_q == 32'h0080_0001 && pend_flags == 32'h0080_0000) |=> video_irq)
        else $error("channel B long field did not raise request");

    a_masked_src: assert property (@(posedge clk) disable iff (!rst_n)
        (pend_flags & src_en_q & `VPI_SRC_MASK) == 32'h0000_0000 |=> !video_irq)
        else $error("masked source raised request");

    a_read_enable: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `VPI_IDX_SRC_EN) |=> reg_rdata == $past(src_en_q))
        else $error("enable readback wrong");

    a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_lane_combine: assert property (@(posedge clk) disable iff (!rst_n)
        irq_raw == (src_en_q[`VPI_BIT_GATE] & (|lane_pass)))
        else $error("combiner disagrees with per-lane gating");

    a_group_split: assert property (@(posedge clk) disable iff (!rst_n)
        irq_raw == (src_en_q[`VPI_BIT_GATE]
            & (grp_cha | grp_chb | grp_disp | grp_misc)))
        else $error("request not covered by the source groups");

    sequence s_en_read;
        reg_rd && reg_addr == `VPI_IDX_SRC_EN;
    endsequence

    a_write_readback: assert property (@(posedge clk) disable iff (!rst_n)
        s_en_write ##1 s_en_read |=> reg_rdata == ($past(reg_wdata, 2) & `VPI_EN_MASK))
        else $error("read straight after write lost the value");

    a_read_pending: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `VPI_IDX_PEND)
            |=> reg_rdata == ($past(pend_flags) & `VPI_SRC_MASK))
        else $error("pending view readback wrong");

    a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr != `VPI_IDX_SRC_EN && reg_addr != `VPI_IDX_PEND)
            |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // ----------------------------------------------------------------
    // Per-source gating checks
    // ----------------------------------------------------------------
    // A lone pending source with its enable and the gate set raises the
    // request a cycle later; with its own enable clear it must stay quiet
    sequence s_lone_enabled(idx);
        src_en_q[`VPI_BIT_GATE] && src_en_q[idx]
            && pend_flags == (32'h0000_0001 << idx);
    endsequence

    sequence s_lone_masked(idx);
        !src_en_q[idx] && pend_flags == (32'h0000_0001 << idx);
    endsequence

    property p_src_raises(idx);
        @(posedge clk) disable iff (!rst_n)
        s_lone_enabled(idx) |=> video_irq;
    endproperty

    property p_src_masked(idx);
        @(posedge clk) disable iff (!rst_n)
        s_lone_masked(idx) |=> !video_irq;
    endproperty

    // Channel B long field
    a_chb_long_on: assert property (p_src_raises(`VPI_BIT_CHB_LONG))
        else $error("channel B long field source did not raise request");
    a_chb_long_off: assert property (p_src_masked(`VPI_BIT_CHB_LONG))
        else $error("channel B long field source was not masked");

    // Channel B short field
    a_chb_short_on: assert property (p_src_raises(`VPI_BIT_CHB_SHORT))
        else $error("channel B short field source did not raise request");
    a_chb_short_off: assert property (p_src_masked(`VPI_BIT_CHB_SHORT))
        else $error("channel B short field source was not masked");

    // Channel B second field vertical
    a_chb_vf2_on: assert property (p_src_raises(`VPI_BIT_CHB_VF2))
        else $error("channel B field 2 source did not raise request");
    a_chb_vf2_off: assert property (p_src_masked(`VPI_BIT_CHB_VF2))
        else $error("channel B field 2 source was not masked");

    // Channel B first field vertical
    a_chb_vf1_on: assert property (p_src_raises(`VPI_BIT_CHB_VF1))
        else $error("channel B field 1 source did not raise request");
    a_chb_vf1_off: assert property (p_src_masked(`VPI_BIT_CHB_VF1))
        else $error("channel B field 1 source was not masked");

    // Channel B sync error
    a_chb_serr_on: assert property (p_src_raises(`VPI_BIT_CHB_SERR))
        else $error("channel B sync error source did not raise request");
    a_chb_serr_off: assert property (p_src_masked(`VPI_BIT_CHB_SERR))
        else $error("channel B sync error source was not masked");

    // Channel B capture complete
    a_chb_done_on: assert property (p_src_raises(`VPI_BIT_CHB_DONE))
        else $error("channel B capture done source did not raise request");
    a_chb_done_off: assert property (p_src_masked(`VPI_BIT_CHB_DONE))
        else $error("channel B capture done source was not masked");

    // Channel B capture overrun
    a_chb_ovr_on: assert property (p_src_raises(`VPI_BIT_CHB_OVR))
        else $error("channel B overrun source did not raise request");
    a_chb_ovr_off: assert property (p_src_masked(`VPI_BIT_CHB_OVR))
        else $error("channel B overrun source was not masked");

    // General purpose pin logic
    a_gpio_on: assert property (p_src_raises(`VPI_BIT_GPIO))
        else $error("pin logic source did not raise request");
    a_gpio_off: assert property (p_src_masked(`VPI_BIT_GPIO))
        else $error("pin logic source was not masked");

    // Display complete not acknowledged
    a_disp_unack_on: assert property (p_src_raises(`VPI_BIT_DISP_UNACK))
        else $error("display unacknowledged source did not raise request");
    a_disp_unack_off: assert property (p_src_masked(`VPI_BIT_DISP_UNACK))
        else $error("display unacknowledged source was not masked");

    // Display complete
    a_disp_done_on: assert property (p_src_raises(`VPI_BIT_DONE))
        else $error("display done source did not raise request");
    a_disp_done_off: assert property (p_src_masked(`VPI_BIT_DONE))
        else $error("display done source was not masked");

    // Display underrun
    a_disp_undr_on: assert property (p_src_raises(`VPI_BIT_DISP_UNDR))
        else $error("display underrun source did not raise request");
    a_disp_undr_off: assert property (p_src_masked(`VPI_BIT_DISP_UNDR))
        else $error("display underrun source was not masked");

    // Channel A long field
    a_cha_long_on: assert property (p_src_raises(`VPI_BIT_CHA_LONG))
        else $error("channel A long field source did not raise request");
    a_cha_long_off: assert property (p_src_masked(`VPI_BIT_CHA_LONG))
        else $error("channel A long field source was not masked");

    // Channel A short field
    a_cha_short_on: assert property (p_src_raises(`VPI_BIT_CHA_SHORT))
        else $error("channel A short field source did not raise request");
    a_cha_short_off: assert property (p_src_masked(`VPI_BIT_CHA_SHORT))
        else $error("channel A short field source was not masked");

    // Channel A second field vertical
    a_cha_vf2_on: assert property (p_src_raises(`VPI_BIT_CHA_VF2))
        else $error("channel A field 2 source did not raise request");
    a_cha_vf2_off: assert property (p_src_masked(`VPI_BIT_CHA_VF2))
        else $error("channel A field 2 source was not masked");

    // Channel A first field vertical
    a_cha_vf1_on: assert property (p_src_raises(`VPI_BIT_CHA_VF1))
        else $error("channel A field 1 source did not raise request");
    a_cha_vf1_off: assert property (p_src_masked(`VPI_BIT_CHA_VF1))
        else $error("channel A field 1 source was not masked");

    // Channel A sync error
    a_cha_serr_on: assert property (p_src_raises(`VPI_BIT_CHA_SERR))
        else $error("channel A sync error source did not raise request");
    a_cha_serr_off: assert property (p_src_masked(`VPI_BIT_CHA_SERR))
        else $error("channel A sync error source was not masked");

    // Channel A capture complete
    a_cha_done_on: assert property (p_src_raises(`VPI_BIT_CHA_DONE))
        else $error("channel A capture done source did not raise request");
    a_cha_done_off: assert property (p_src_masked(`VPI_BIT_CHA_DONE))
        else $error("channel A capture done source was not masked");

    // Channel A capture overrun
    a_cha_ovr_on: assert property (p_src_raises(`VPI_BIT_CHA_OVR))
        else $error("channel A overrun source did not raise request");
    a_cha_ovr_off: assert property (p_src_masked(`VPI_BIT_CHA_OVR))
        else $error("channel A overrun source was not masked");

    // System time clock tick
    a_tick_on: assert property (p_src_raises(`VPI_BIT_TICK))
        else $error("time clock tick source did not raise request");
    a_tick_off: assert property (p_src_masked(`VPI_BIT_TICK))
        else $error("time clock tick source was not masked");

    // System time clock event
    a_systime_on: assert property (p_src_raises(`VPI_BIT_SYSTIME))
        else $error("time clock source did not raise request");
    a_systime_off: assert property (p_src_masked(`VPI_BIT_SYSTIME))
        else $error("time clock source was not masked");
endmodule : vpi_irq_enable

// [video_irq_source_enable_cfg.svh]
// Constants for the video port interrupt enable block
`ifndef VPI_CFG_SVH
`define VPI_CFG_SVH

// Register indices (byte address = 4 * index)
`define VPI_IDX_SRC_EN        4'h0
`define VPI_IDX_PEND          4'h1
`define VPI_ADDR_W            4

// Enable register field positions
`define VPI_BIT_GATE          0
`define VPI_BIT_CHA_OVR       1
`define VPI_BIT_CHA_DONE      2
`define VPI_BIT_CHA_SERR      3
`define VPI_BIT_CHA_VF1       4
`define VPI_BIT_CHA_VF2       5
`define VPI_BIT_CHA_SHORT     6
`define VPI_BIT_CHA_LONG      7
`define VPI_BIT_SYSTIME       10
`define VPI_BIT_TICK          11
`define VPI_BIT_DISP_UNDR     12
`define VPI_BIT_DONE          13
`define VPI_BIT_DISP_UNACK    14
`define VPI_BIT_GPIO          16
`define VPI_BIT_CHB_OVR       17
`define VPI_BIT_CHB_DONE      18
`define VPI_BIT_CHB_SERR      19
`define VPI_BIT_CHB_VF1       20
`define VPI_BIT_CHB_VF2       21
`define VPI_BIT_CHB_SHORT     22
`define VPI_BIT_CHB_LONG      23

// Writable mask and reset value
`define VPI_EN_MASK           32'h00FF_7CFF
`define VPI_SRC_MASK          32'h00FF_7CFE
`define VPI_EN_RESET          32'h0000_0000

`endif

// [vpi_pkg.sv]
// Types shared by the video port interrupt enable block
package vpi_pkg;
    typedef logic [31:0] vpi_word_t;
    typedef logic [3:0]  vpi_addr_t;
endpackage : vpi_pkg

// [vpi_irq_combine.sv]
// Masked OR of pending flags gated by the global enable
`timescale 1ns/100ps
`include "video_irq_source_enable_cfg.svh"
module vpi_irq_combine (
    // Pending flags and enables
    input  wire vpi_pkg::vpi_word_t pend,
    input  wire vpi_pkg::vpi_word_t enable,
    // Combined request, unregistered
    output logic                    irq_raw
);
    import vpi_pkg::*;

    // Each source passes only where its own enable is set
    always_comb begin
        irq_raw = enable[`VPI_BIT_GATE]
                  & (|(pend & enable & `VPI_SRC_MASK));
    end
endmodule : vpi_irq_combine

// [vpi_flag_src.sv]
// Pending flag source standing in for the outside status register
`timescale 1ns/100ps
module vpi_flag_src (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Set and clear requests
    input  wire logic [31:0] set_bits,
    input  wire logic        clr_all,
    // Recorded flags
    output logic      [31:0] pend_flags
);
    // Flags stick until cleared, whatever the enables hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pend_flags <= 32'h0000_0000;
        else if (clr_all) pend_flags <= 32'h0000_0000;
        else pend_flags <= pend_flags | set_bits;
    end
endmodule : vpi_flag_src

// [video_port_irq_enable_tb_top.sv]
// Self-checking bench for the interrupt enable register
`timescale 1ns/100ps
`include "video_irq_source_enable_cfg.svh"
module video_port_irq_enable_tb_top;
    import vpi_pkg::*;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clr_all = 0, video_irq;
    vpi_addr_t   reg_addr = 4'h0;
    vpi_word_t   reg_wdata = '0, set_bits = '0, pend_flags;
    logic [31:0] reg_rdata, d;
    int          n_mismatch = 0, checks = 0;
    // Clock of 100 ns period
    always #50 clk = ~clk;
    vpi_irq_enable vpi_irq_enable_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pend_flags(pend_flags), .video_irq(video_irq));
    vpi_flag_src vpi_flag_src_inst (.clk(clk), .rst_n(rst_n), .set_bits(set_bits),
        .clr_all(clr_all), .pend_flags(pend_flags));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
        @(posedge clk); reg_wr <= 0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk); reg_rd <= 1; reg_addr <= a;
        @(posedge clk); reg_rd <= 0;
        #1 v = reg_rdata;
    endtask : rd
    // Write the enable register and read it back with no gap between strobes
    task wr_rd(input logic [31:0] v, output logic [31:0] r);
        @(posedge clk); reg_wr <= 1; reg_addr <= 4'h0; reg_wdata <= v;
        @(posedge clk); reg_wr <= 0; reg_rd <= 1;
        @(posedge clk); reg_rd <= 0;
        #1 r = reg_rdata;
    endtask : wr_rd
    // Clear then raise flags; waits out the registered request
    task flags(input logic [31:0] s);
        @(posedge clk); clr_all <= 1;
        @(posedge clk); clr_all <= 0; set_bits <= s;
        @(posedge clk); set_bits <= 0;
        repeat (2) @(posedge clk);
        #1;
    endtask : flags
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task test_reset;
        rd(4'h0, d); chk(d, 32'h0000_0000);
        @(posedge clk); #1 chk(reg_rdata, 32'h0000_0000);
        flags(32'hFFFF_FFFF); chk(video_irq, 1'b0);
        rd(4'h1, d); chk(d, 32'h00FF_7CFE);
        $display("test_reset done");
    endtask : test_reset
    task test_fields;
        wr(4'h0, 32'hFFFF_FFFF); rd(4'h0, d); chk(d, 32'h00FF_7CFF);
        rd(4'h2, d); chk(d, 32'h0000_0000);
        rd(4'h0, d); chk(d, 32'h00FF_7CFF);
        flags(~`VPI_SRC_MASK); chk(video_irq, 1'b0);
        wr(4'h0, 32'h0000_0000); rd(4'h0, d); chk(d, 32'h0000_0000);
        wr_rd(32'h0000_5A5A, d); chk(d, 32'h0000_585A);
        wr(4'h0, 32'h0000_0000);
        $display("test_fields done");
    endtask : test_fields
    // Each source alone, all other sources together, then with its own enable clear and without the gate
    task test_sources;
        logic [31:0] b;
        for (int i = 1; i < 24; i++) begin
            b = 32'h0000_0001 << i;
            if ((`VPI_SRC_MASK & b) == 0) continue;
            wr(4'h0, b | 32'h0000_0001);
            flags(b); chk(video_irq, 1'b1);
            flags(`VPI_SRC_MASK & ~b); chk(video_irq, 1'b0);
            flags(b); wr(4'h0, 32'h0000_0001);
            repeat (2) @(posedge clk);
            #1 chk(video_irq, 1'b0);
            wr(4'h0, b);
            repeat (2) @(posedge clk);
            #1 chk(video_irq, 1'b0);
        end
        $display("test_sources done");
    endtask : test_sources
    // Reset in mid-run clears enables and drops a standing request
    task test_midreset;
        wr(4'h0, 32'hFFFF_FFFF); flags(32'h0080_0000); chk(video_irq, 1'b1);
        @(posedge clk); rst_n <= 0;
        repeat (2) @(posedge clk);
        #1 chk(video_irq, 1'b0);
        @(posedge clk); rst_n <= 1;
        rd(4'h0, d); chk(d, 32'h0000_0000);
        flags(32'h0080_0000); chk(video_irq, 1'b0);
        $display("test_midreset done");
    endtask : test_midreset
    task give_verdict;
        $display("Mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // Main sequence: ten cycles of reset, then the scenarios
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        test_reset;
        test_fields;
        test_sources;
        test_midreset;
        give_verdict;
    end
    // Watchdog well past the expected run of some 56 us
    initial begin
        #500000;
        n_mismatch++;
        give_verdict;
    end
endmodule : video_port_irq_enable_tb_top
